// [hw/ccms_pkg.sv]
// Shared constants and types for the CPU clock mode select block
package ccms_pkg;
	// Register byte offsets
	localparam logic [7:0] ofs_config_latch = 8'h00;
	localparam logic [7:0] ofs_reset_control = 8'h04;
	localparam logic [7:0] ofs_reload_cmd = 8'h08;
	localparam logic [7:0] ofs_status = 8'h0c;
	// Field positions
	localparam int mode_msb = 7;
	localparam int mode_lsb = 5;
	localparam int reset_control_reg_upper_lsb = 8;
	localparam int reload_bit = 0;
	localparam int status_lock_bit = 3;
	localparam int status_len_lsb = 4;
	// Reset values
	localparam logic [7:0] config_latch_reset = 8'hff;
	localparam logic [15:0] reset_control_reset = 16'hff00;
	localparam logic [11:0] half_len_reset = 12'h005;
	// Mode field codes
	localparam logic [2:0] mode_pll_x4 = 3'h7;
	localparam logic [2:0] mode_pll_x3 = 3'h6;
	localparam logic [2:0] mode_pll_x2 = 3'h5;
	localparam logic [2:0] mode_pll_x5 = 3'h4;
	localparam logic [2:0] mode_direct = 3'h3;
	localparam logic [2:0] mode_pll_x1p5 = 3'h2;
	localparam logic [2:0] mode_prescale = 3'h1;
	localparam logic [2:0] mode_pll_x2p5 = 3'h0;
	// Timing: clock rate and smallest half period the PLL path may shrink to
	localparam int hclk_mhz = 100;
	localparam int min_half_ns = 10;
	localparam logic [11:0] min_half_cycles = 12'((min_half_ns * hclk_mhz + 999) / 1000);
	typedef enum logic [1:0] {
		ccms_path_pll,
		ccms_path_direct,
		ccms_path_prescale
	} ccms_path_t;
endpackage : ccms_pkg

// [hw/ccms_top.sv]
// CPU clock generator with mode latch, prescaler, direct drive and digital PLL
// Contract
// - Both CPU clock edges matter; spacing between edges is the half period.
// - Clock path is chosen by mode field, bits 7 to 5 of config latch.
// - Long hardware reset captures upper port-0 byte into the config latch.
// - Software may reload config latch from upper byte of reset control register.
// - Codes: 111 x4, 110 x3, 101 x2, 100 x5, 010 x1.5, 000 x2.5, 011 direct, 001 prescale.
// - Code 001 gives CPU clock at half oscillator frequency through prescaler.
// - Prescaler high and low times each equal one oscillator period.
// - PLL codes enable the PLL; CPU clock is oscillator times the factor.
// - PLL resyncs every factor-count input transitions for integer factors, every two for x1.5 and x2.5, adjusting frequency gradually.
// - Code 011 disables PLL and drives CPU clock straight from oscillator.
// - Direct drive half periods follow input duty; two always span one period.
// - Emulation mode inverts the sampled top configuration pin, mode bit 7.
`timescale 1ns/1ns
`default_nettype none
module ccms_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	input wire logic osc_in,
	input wire logic [7:0] port0_upper_byte,
	input wire logic long_hw_reset,
	input wire logic emulation_mode,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic cpu_clk,
	output logic pll_enable
);
	// Path chosen by a mode code
	function automatic ccms_pkg::ccms_path_t path_of(input logic [2:0] code);
		unique case (code)
			ccms_pkg::mode_direct: path_of = ccms_pkg::ccms_path_direct;
			ccms_pkg::mode_prescale: path_of = ccms_pkg::ccms_path_prescale;
			default: path_of = ccms_pkg::ccms_path_pll;
		endcase
	endfunction : path_of

	// CPU half periods per resync window: factor times window transitions
	function automatic logic [7:0] halves_of(input logic [2:0] code);
		unique case (code)
			ccms_pkg::mode_pll_x4: halves_of = 8'd16;
			ccms_pkg::mode_pll_x3: halves_of = 8'd9;
			ccms_pkg::mode_pll_x2: halves_of = 8'd4;
			ccms_pkg::mode_pll_x5: halves_of = 8'd25;
			ccms_pkg::mode_pll_x1p5: halves_of = 8'd3;
			ccms_pkg::mode_pll_x2p5: halves_of = 8'd5;
			default: halves_of = 8'd2;
		endcase
	endfunction : halves_of

	// Oscillator transitions per resync window
	function automatic logic [3:0] window_of(input logic [2:0] code);
		unique case (code)
			ccms_pkg::mode_pll_x4: window_of = 4'd4;
			ccms_pkg::mode_pll_x3: window_of = 4'd3;
			ccms_pkg::mode_pll_x2: window_of = 4'd2;
			ccms_pkg::mode_pll_x5: window_of = 4'd5;
			default: window_of = 4'd2;
		endcase
	endfunction : window_of

	// Write strobe for one register offset, shared by every writable register
	function automatic logic wr_hit(input logic wr, input logic [7:0] addr,
		input logic [7:0] ofs);
		wr_hit = wr && (addr == ofs);
	endfunction : wr_hit

	// Register state
	logic [7:0] reset_config_latch;
	logic [15:0] reset_control_reg;
	logic [2:0] clock_mode_field;
	logic [2:0] mode_q;
	ccms_pkg::ccms_path_t path;
	// Clock generation state
	logic osc_q;
	logic osc_rise;
	logic osc_edge;
	logic [3:0] trans_cnt;
	logic [15:0] span_cnt;
	logic [11:0] half_len;
	logic [11:0] half_cnt;
	logic [15:0] span_now;
	logic [15:0] span_goal;
	logic [3:0] win_trans;
	logic win_end;
	logic pll_locked;
	logic mode_changed;
	logic pll_hold;
	logic half_due;
	// Bus state
	logic bus_take;
	logic dp_write;
	logic [7:0] dp_addr;
	logic rd_pend;
	logic [7:0] rd_addr;
	logic addr_ok;
	logic sw_reload;
	logic [31:0] next_rdata;

	assign clock_mode_field = reset_config_latch[ccms_pkg::mode_msb:ccms_pkg::mode_lsb];
	assign path = path_of(clock_mode_field);
	assign osc_rise = osc_in & ~osc_q;
	assign osc_edge = osc_in ^ osc_q;
	assign win_trans = window_of(clock_mode_field);
	assign win_end = osc_edge && (trans_cnt == win_trans - 4'd1);
	assign span_now = span_cnt + 16'd1;
	// Window length in hclk cycles that the current half length would give
	assign span_goal = 16'(half_len) * 16'(halves_of(clock_mode_field));
	assign mode_changed = (mode_q != clock_mode_field);
	// PLL window restarts whenever the mode moves or the path leaves the PLL
	assign pll_hold = mode_changed || (path != ccms_pkg::ccms_path_pll);
	assign addr_ok = (haddr[1:0] == 2'b00);
	assign bus_take = hsel && htrans[1] && hready && (hsize == 3'b010) && addr_ok;
	assign sw_reload = wr_hit(dp_write, dp_addr, ccms_pkg::ofs_reload_cmd)
		&& hwdata[ccms_pkg::reload_bit];

	// Config latch: hardware capture wins over a software reload in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			reset_config_latch <= ccms_pkg::config_latch_reset;
		end else if (clk_en) begin
			if (long_hw_reset) begin
				reset_config_latch <= {port0_upper_byte[7] ^ emulation_mode,
					port0_upper_byte[6:0]};
			end else if (sw_reload) begin
				reset_config_latch <= reset_control_reg[15:ccms_pkg::reset_control_reg_upper_lsb];
			end
		end
	end

	// Software-written reset control register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			reset_control_reg <= ccms_pkg::reset_control_reset;
		end else if (clk_en) begin
			if (wr_hit(dp_write, dp_addr, ccms_pkg::ofs_reset_control)) begin
				reset_control_reg <= hwdata[15:0];
			end
		end
	end

	// Oscillator sampled once per hclk; it must run slower than hclk/2
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			osc_q <= 1'b0;
		end else if (clk_en) begin
			osc_q <= osc_in;
		end
	end

	// Mode of the previous cycle, so a change can restart the PLL window
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_q <= ccms_pkg::config_latch_reset[ccms_pkg::mode_msb:ccms_pkg::mode_lsb];
		end else if (clk_en) begin
			mode_q <= clock_mode_field;
		end
	end

	// PLL enable follows the path, registered for a clean output
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pll_enable <= 1'b1;
		end else if (clk_en) begin
			pll_enable <= (path == ccms_pkg::ccms_path_pll);
		end
	end

	// Oscillator transitions inside the current resync window
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trans_cnt <= 4'd0;
		end else if (clk_en) begin
			if (pll_hold || win_end) begin
				trans_cnt <= 4'd0;
			end else if (osc_edge) begin
				trans_cnt <= trans_cnt + 4'd1;
			end
		end
	end

	// hclk cycles inside the window, saturating if the oscillator stalls
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			span_cnt <= 16'd0;
		end else if (clk_en) begin
			if (pll_hold || win_end) begin
				span_cnt <= 16'd0;
			end else if (span_cnt != 16'hffff) begin
				span_cnt <= span_cnt + 16'd1;
			end
		end
	end

	// One step per window so the frequency never jumps
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			half_len <= ccms_pkg::half_len_reset;
		end else if (clk_en && !pll_hold && win_end) begin
			if (span_now > span_goal) begin
				half_len <= half_len + 12'd1;
			end else if (span_now < span_goal && half_len > ccms_pkg::min_half_cycles) begin
				half_len <= half_len - 12'd1;
			end
		end
	end

	// Lock means the last whole window matched the target span exactly
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pll_locked <= 1'b0;
		end else if (clk_en) begin
			if (pll_hold) begin
				pll_locked <= 1'b0;
			end else if (win_end) begin
				pll_locked <= (span_now == span_goal);
			end
		end
	end

	// Current PLL half period has run its full length
	assign half_due = (half_cnt >= half_len - 12'd1);

	// CPU clock: every toggle is one half period edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cpu_clk <= 1'b0;
		end else if (clk_en) begin
			unique case (path)
				ccms_pkg::ccms_path_direct: begin
					cpu_clk <= osc_in;
				end
				ccms_pkg::ccms_path_prescale: begin
					// Toggling on rising edges only makes duty independent of the input
					if (osc_rise) begin
						cpu_clk <= ~cpu_clk;
					end
				end
				ccms_pkg::ccms_path_pll: begin
					// A resync edge that is due still toggles, so locked halves stay even
					if (half_due) begin
						cpu_clk <= ~cpu_clk;
					end
				end
			endcase
		end
	end

	// PLL half period counter, restarted at each window end to stay locked
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			half_cnt <= 12'd0;
		end else if (clk_en) begin
			if (path != ccms_pkg::ccms_path_pll || win_end || half_due) begin
				half_cnt <= 12'd0;
			end else begin
				half_cnt <= half_cnt + 12'd1;
			end
		end
	end

	// Write data phase target, committed on the edge that ends the phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_write <= 1'b0;
			dp_addr <= 8'h00;
		end else if (clk_en) begin
			dp_write <= bus_take && hwrite;
			if (bus_take) begin
				dp_addr <= haddr[7:0];
			end
		end
	end

	// Reads take one wait state so the mux sees settled register values
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_pend <= 1'b0;
			rd_addr <= 8'h00;
		end else if (clk_en) begin
			rd_pend <= bus_take && !hwrite;
			if (bus_take && !hwrite) begin
				rd_addr <= haddr[7:0];
			end
		end
	end

	// Ready drops for exactly the read wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
		end else if (clk_en) begin
			hreadyout <= !(bus_take && !hwrite);
		end
	end

	// Every access completes OKAY, refused ones included
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp <= 1'b0;
		end else if (clk_en) begin
			hresp <= 1'b0;
		end
	end

	// Read mux; unmapped offsets read as zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (rd_addr)
			ccms_pkg::ofs_config_latch: next_rdata[7:0] = reset_config_latch;
			ccms_pkg::ofs_reset_control: next_rdata[15:0] = reset_control_reg;
			ccms_pkg::ofs_status: begin
				next_rdata[1:0] = path;
				next_rdata[2] = pll_enable;
				next_rdata[ccms_pkg::status_lock_bit] = pll_locked;
				next_rdata[ccms_pkg::status_len_lsb +: 12] = half_len;
			end
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	// Read data holds until the next read completes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (clk_en && rd_pend) begin
			hrdata <= next_rdata;
		end
	end
endmodule : ccms_top
`default_nettype wire

// [bench/ccms_assertions.sv]
// Port-level checks for the CPU clock mode select block
`timescale 1ns/1ns
`default_nettype none
module ccms_checker (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic osc_in,
	input wire logic [7:0] port0_upper_byte,
	input wire logic long_hw_reset,
	input wire logic emulation_mode,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic cpu_clk,
	input wire logic pll_enable
);
	logic take, rd_take, wr_take, wp, q1, q2, q3, pre3, dir3;
	logic [7:0] wa, lat;
	logic [15:0] rc;
	logic [2:0] m1, m2;
	assign take = hsel && htrans[1] && hready && hsize == 3'h2 && haddr[1:0] == 2'h0;
	assign rd_take = take && !hwrite;
	assign wr_take = take && hwrite;
	assign pre3 = lat[7:5] == 3'h1 && m1 == 3'h1 && m2 == 3'h1;
	assign dir3 = lat[7:5] == 3'h3 && m1 == 3'h3 && m2 == 3'h3;
	// Shadow latch, so path checks know which mode is selected
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wp <= 1'b0;
			wa <= 8'h00;
			rc <= 16'hff00;
			lat <= 8'hff;
		end else begin
			wp <= wr_take;
			wa <= haddr[7:0];
			if (wp && wa == 8'h04)
				rc <= hwdata[15:0];
			if (long_hw_reset)
				lat <= port0_upper_byte ^ {emulation_mode, 7'h00};
			else if (wp && wa == 8'h08 && hwdata[0])
				lat <= rc[15:8];
		end
	end
	// Mode and oscillator history; path lags latch, so checks wait for it to settle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{m1, m2} <= 6'h3f;
			{q1, q2, q3} <= 3'h0;
		end else begin
			m1 <= lat[7:5];
			m2 <= m1;
			{q1, q2, q3} <= {osc_in, q1, q2};
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	hresp_okay_a: assert property (hresp == 1'b0) else $error("hresp not okay");
	read_wait_a: assert property (rd_take |=> !hreadyout ##1 hreadyout) else $error("rd wait");
	write_nowait_a: assert property (wr_take |=> hreadyout) else $error("wr wait");
	rdata_hold_a: assert property (
		hreadyout && $past(hreadyout) |-> $stable(hrdata)) else $error("hrdata moved");
	pll_en_mode_a: assert property (
		pll_enable == (m1 != 3'h3 && m1 != 3'h1)) else $error("pll_enable wrong");
	direct_follow_a: assert property (
		dir3 |-> cpu_clk == $past(osc_in)) else $error("direct not following");
	pre_toggle_a: assert property (
		pre3 && osc_in && !q1 |-> ##[1:2] (cpu_clk != $past(cpu_clk))) else $error("no toggle");
	pre_quiet_a: assert property (
		pre3 && !(osc_in && !q1) && !(q1 && !q2) && !(q2 && !q3) |-> $stable(cpu_clk))
		else $error("stray toggle");
endmodule : ccms_checker
`default_nettype wire

// [bench/ccms_osc_model.sv]
// Free-running oscillator with settable high and low times
`timescale 1ns/1ns
`default_nettype none
module ccms_osc_model (
	input wire logic hclk,
	input var int hi_len,
	input var int lo_len,
	output logic osc_in
);
	int cnt = 0;
	initial osc_in = 1'b0;
	// Steps on hclk so each phase is a whole number of cycles
	always @(posedge hclk) begin
		cnt <= cnt + 1;
		if (cnt + 1 >= (osc_in ? hi_len : lo_len)) begin
			cnt <= 0;
			osc_in <= ~osc_in;
		end
	end
endmodule : ccms_osc_model
`default_nettype wire

// [bench/ccms_top_tb.sv]
// Self-checking bench for the CPU clock mode select block
`timescale 1ns/1ns
`default_nettype none
module ccms_top_tb;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic clk_en = 1'b1;
	logic osc_in, hready, hreadyout, hresp, cpu_clk, pll_enable, rdy_q;
	logic [7:0] port0_upper_byte = 8'h00;
	logic long_hw_reset = 1'b0;
	logic emulation_mode = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, rd_q, d, w;
	logic [7:0] b;
	int osc_hi = 60;
	int osc_lo = 60;
	int mismatches = 0;
	int check_count = 0;
	int hi, lo, prev, e, k;
	logic [2:0] pll_modes [6] = '{3'h7, 3'h4, 3'h6, 3'h0, 3'h5, 3'h2};
	int halves [6] = '{15, 12, 20, 24, 30, 40};
	assign hready = hreadyout;
	always #5 hclk = ~hclk;
	// Captured mid-cycle: the value the slave presents at the next rising edge
	always @(negedge hclk) begin
		rdy_q = hreadyout;
		rd_q = hrdata;
	end
	ccms_top u_ccms_top (.hclk, .hresetn, .clk_en, .osc_in, .port0_upper_byte, .long_hw_reset,
		.emulation_mode, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
		.hreadyout, .hresp, .cpu_clk, .pll_enable);
	ccms_osc_model u_ccms_osc_model (.hclk(hclk), .hi_len(osc_hi), .lo_len(osc_lo), .osc_in(osc_in));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task print_verdict;
		if (mismatches == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : print_verdict
	task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge hclk);
		while (rdy_q !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (rdy_q !== 1'b1) @(posedge hclk);
		d = rd_q;
	endtask : bus
	// Waits out one full resync window so stale lock state is gone
	task sel(input logic [2:0] m);
		bus(1'b1, 32'h04, {16'h0, m, 13'h0});
		bus(1'b1, 32'h08, 32'h1);
		repeat (320) @(posedge hclk);
	endtask : sel
	task meas;
		hi = 0;
		lo = 0;
		@(negedge hclk iff cpu_clk === 1'b0);
		@(negedge hclk iff cpu_clk === 1'b1);
		while (cpu_clk === 1'b1) begin
			hi++;
			@(negedge hclk);
		end
		while (cpu_clk === 1'b0) begin
			lo++;
			@(negedge hclk);
		end
	endtask : meas
	function automatic logic [2:0] ep(input logic [2:0] m);
		return m == 3'h3 ? 3'h1 : m == 3'h1 ? 3'h2 : 3'h4;
	endfunction : ep
	initial begin
		void'($urandom(68439));
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, 32'h00, 32'h0);
		chk(d, 32'hff);
		bus(1'b0, 32'h04, 32'h0);
		chk(d, 32'hff00);
		bus(1'b0, 32'h0c, 32'h0);
		chk(d & 32'hfff7, 32'h54);
		bus(1'b1, 32'h00, 32'h0);
		bus(1'b0, 32'h00, 32'h0);
		chk(d, 32'hff);
		bus(1'b0, 32'h10, 32'h0);
		chk(d, 32'h0);
		for (k = 0; k < 4; k++) begin
			b = 8'($urandom);
			port0_upper_byte <= b;
			emulation_mode <= k[0];
			long_hw_reset <= 1'b1;
			repeat (2) @(posedge hclk);
			long_hw_reset <= 1'b0;
			bus(1'b0, 32'h00, 32'h0);
			chk(d, {24'h0, b ^ {k[0], 7'h0}});
		end
		for (k = 0; k < 8; k++) begin
			w = {16'h0, k[2:0], 13'($urandom)};
			bus(1'b1, 32'h04, w);
			bus(1'b0, 32'h04, 32'h0);
			chk(d, w);
			bus(1'b1, 32'h08, 32'h1);
			bus(1'b0, 32'h00, 32'h0);
			chk(d, {24'h0, w[15:8]});
			bus(1'b0, 32'h0c, 32'h0);
			chk(d[2:0], ep(k[2:0]));
			@(negedge hclk);
			chk(pll_enable, 32'(ep(k[2:0]) >> 2));
		end
		osc_hi <= 30;
		osc_lo <= 90;
		sel(3'h3);
		meas();
		meas();
		chk(hi, 30);
		chk(lo, 90);
		sel(3'h1);
		meas();
		meas();
		chk(hi, 120);
		chk(lo, 120);
		osc_hi <= 60;
		osc_lo <= 60;
		for (k = 0; k < 6; k++) begin
			sel(pll_modes[k]);
			prev = -1;
			d = 32'h0;
			for (int n = 0; n < 3000 && d[3] !== 1'b1; n++) begin
				bus(1'b0, 32'h0c, 32'h0);
				e = int'(d[15:4]) - prev;
				if (prev >= 0)
					chk(32'(e * e <= 1), 32'h1);
				prev = int'(d[15:4]);
			end
			chk(d[15:4], halves[k]);
			meas();
			meas();
			chk(hi, halves[k]);
			chk(lo, halves[k]);
		end
		print_verdict();
	end
	initial begin
		#800000;
		mismatches++;
		print_verdict();
	end
endmodule : ccms_top_tb
bind ccms_top ccms_checker u_ccms_checker (.hclk, .hresetn, .osc_in, .port0_upper_byte,
	.long_hw_reset, .emulation_mode, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
	.hrdata, .hreadyout, .hresp, .cpu_clk, .pll_enable);
`default_nettype wire
